// [logic/dbs_top.sv]
/*
 * DC braking sequencer: APB register file, stop handling, demagnetisation
 * wait, timed DC braking and optional DC holding.
 * Assumes an APB master on pclk and asynchronous start/stop pins.
 */
// Chosen here: the address map and the APB register port.
// Summary of operation
// - The braking mode setting spans off to externally requested braking and is off after reset.
// - Mode 0 disables braking, mode 1 brakes after start is withdrawn, mode 2 brakes on external stop.
// - Braking current is a percentage of rated current from 0 to 180, default 80.
// - DC injection waits a demagnetisation delay of 0.10 to 10.00 s, default 2 s.
// - A new start is ignored during the minimum braking time of 0 to 65535 ms, default 0.
// - Between minimum and maximum braking time a start ends DC braking at once.
// - Maximum braking time of 0 to 60 s, default 15, counts from the same origin as the minimum.
// - During DC braking the holding brake function has no effect on the brake output.
// - In mode 1, both starts low brake with DC instead of the stop ramp.
// - A stop coasts, ramps down or brakes with DC depending on configuration.
// - DC holding may follow completed DC braking directly.
// - Holding starts at the end of maximum braking time when its duration is nonzero.
module dbs_top #(
    parameter int CYC_PER_MS = dbs_pkg::CYC_PER_MS
) (
    // Clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // APB slave
    input  wire logic [7:0]             paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    input  wire logic [3:0]             pstrb,
    output      logic [31:0]            prdata,
    output      logic                   pready,
    output      logic                   pslverr,
    // Pins
    input  wire logic                   start_clockwise,
    input  wire logic                   start_anticlockwise,
    input  wire logic                   stop_req_n,
    input  wire logic                   motor_holding_brake_fn,
    // Drive commands
    output      dbs_pkg::dbs_drive_type drive
);

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                            input logic [3:0] strb);
        logic [15:0] r;
        r = old;
        if (strb[0]) begin
            r[7:0] = wd[7:0];
        end
        if (strb[1]) begin
            r[15:8] = wd[15:8];
        end
        return r;
    endfunction : merge16

    function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
                                            input logic [15:0] hi);
        logic [15:0] r;
        r = v;
        if (v < lo) begin
            r = lo;
        end else if (v > hi) begin
            r = hi;
        end
        return r;
    endfunction : clamp16

    function automatic logic mapped(input logic [7:0] a);
        return a == dbs_pkg::OFS_CTRL || a == dbs_pkg::OFS_CURRENT || a == dbs_pkg::OFS_DEMAG ||
               a == dbs_pkg::OFS_MIN || a == dbs_pkg::OFS_MAX || a == dbs_pkg::OFS_HOLD ||
               a == dbs_pkg::OFS_STATUS;
    endfunction : mapped

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        dbs_pkg::dbs_cfg_type   cfg;
        dbs_pkg::dbs_state_type st;
        logic [16:0]            cnt;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
        dbs_pkg::dbs_drive_type drv;
    } dbs_top_state_type;

    localparam dbs_pkg::dbs_cfg_type CFG_RST = '{
        dc_brake_mode_sel:    dbs_pkg::MODE_OFF,
        sw_stop:              1'b0,
        stop_action:          dbs_pkg::ACT_COAST,
        dc_brake_current_set: dbs_pkg::CURRENT_RST,
        demag_delay:          dbs_pkg::DEMAG_RST,
        brake_time_min:       dbs_pkg::MIN_RST,
        brake_time_max:       dbs_pkg::MAX_S_RST,
        dc_hold_duration:     dbs_pkg::HOLD_RST
    };

    dbs_top_state_type    state_r;
    dbs_top_state_type    state_nxt;
    dbs_pkg::dbs_pin_type pin_async;
    dbs_pkg::dbs_pin_type pin_s;
    logic                 ms_tick;
    logic                 ten_ms_tick;

    // ****************************************************************
    // Pin synchronisation and time base
    // ****************************************************************
    assign pin_async = '{
        start_clockwise:        start_clockwise,
        start_anticlockwise:    start_anticlockwise,
        stop_req_n:             stop_req_n,
        motor_holding_brake_fn: motor_holding_brake_fn
    };

    dbs_sync u_sync (
        .pclk      (pclk),
        .presetn   (presetn),
        .pin_async (pin_async),
        .pin_sync  (pin_s)
    );

    dbs_tick #(
        .CYC_PER_MS (CYC_PER_MS)
    ) u_tick (
        .pclk        (pclk),
        .presetn     (presetn),
        .ms_tick     (ms_tick),
        .ten_ms_tick (ten_ms_tick)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    logic        start;
    logic        stop_req;
    logic        brk_cancel;
    logic        brk_ext;
    logic        blocked;
    logic [16:0] max_ms;

    always_comb begin
        state_nxt = state_r;
        start     = pin_s.start_clockwise | pin_s.start_anticlockwise;
        stop_req  = ~pin_s.stop_req_n | state_r.cfg.sw_stop;
        // Mode code 3 acts as off
        brk_cancel = state_r.cfg.dc_brake_mode_sel == dbs_pkg::MODE_AFTER_CANCEL;
        brk_ext    = state_r.cfg.dc_brake_mode_sel == dbs_pkg::MODE_EXT_STOP;
        blocked    = brk_ext & stop_req;
        max_ms     = 17'(state_r.cfg.brake_time_max * 16'(dbs_pkg::MS_PER_S));

        // Bus: answer decided in setup phase, write at access edge
        if (psel && !penable) begin
            state_nxt.pready  = 1'b1;
            state_nxt.pslverr = !mapped(paddr) || (pwrite && paddr == dbs_pkg::OFS_STATUS);
            state_nxt.prdata  = 32'h0000_0000;
            if (!pwrite) begin
                unique case (paddr)
                    dbs_pkg::OFS_CTRL: begin
                        state_nxt.prdata[4:0] = {state_r.cfg.stop_action, state_r.cfg.sw_stop,
                                                 state_r.cfg.dc_brake_mode_sel};
                    end

                    dbs_pkg::OFS_CURRENT: begin
                        state_nxt.prdata[7:0] = state_r.cfg.dc_brake_current_set;
                    end

                    dbs_pkg::OFS_DEMAG: begin
                        state_nxt.prdata[15:0] = state_r.cfg.demag_delay;
                    end

                    dbs_pkg::OFS_MIN: begin
                        state_nxt.prdata[15:0] = state_r.cfg.brake_time_min;
                    end

                    dbs_pkg::OFS_MAX: begin
                        state_nxt.prdata[15:0] = state_r.cfg.brake_time_max;
                    end

                    dbs_pkg::OFS_HOLD: begin
                        state_nxt.prdata[15:0] = state_r.cfg.dc_hold_duration;
                    end

                    dbs_pkg::OFS_STATUS: begin
                        state_nxt.prdata[2:0]                = state_r.st;
                        state_nxt.prdata[dbs_pkg::POS_INJECT] = state_r.drv.dc_inject;
                    end

                    default: begin
                        state_nxt.prdata = 32'h0000_0000;
                    end
                endcase
            end
        end
        if (psel && penable && pwrite && !state_r.pslverr) begin
            unique case (paddr)
                dbs_pkg::OFS_CTRL: begin
                    if (pstrb[0]) begin
                        state_nxt.cfg.dc_brake_mode_sel = pwdata[dbs_pkg::POS_MODE +: 2];
                        state_nxt.cfg.sw_stop           = pwdata[dbs_pkg::POS_SWSTOP];
                        state_nxt.cfg.stop_action       = pwdata[dbs_pkg::POS_STOPACT +: 2];
                    end
                end

                dbs_pkg::OFS_CURRENT: begin
                    if (pstrb[0]) begin
                        state_nxt.cfg.dc_brake_current_set =
                            (pwdata[7:0] > dbs_pkg::CURRENT_MAX) ? dbs_pkg::CURRENT_MAX : pwdata[7:0];
                    end
                end

                dbs_pkg::OFS_DEMAG: begin
                    state_nxt.cfg.demag_delay = clamp16(merge16(state_r.cfg.demag_delay, pwdata, pstrb),
                                                        dbs_pkg::DEMAG_MIN, dbs_pkg::DEMAG_MAX);
                end

                dbs_pkg::OFS_MIN: begin
                    state_nxt.cfg.brake_time_min = merge16(state_r.cfg.brake_time_min, pwdata, pstrb);
                end

                dbs_pkg::OFS_MAX: begin
                    state_nxt.cfg.brake_time_max = clamp16(merge16(state_r.cfg.brake_time_max, pwdata, pstrb),
                                                           16'h0000, dbs_pkg::MAX_S_MAX);
                end

                dbs_pkg::OFS_HOLD: begin
                    state_nxt.cfg.dc_hold_duration = clamp16(merge16(state_r.cfg.dc_hold_duration, pwdata, pstrb),
                                                             16'h0000, dbs_pkg::HOLD_MAX);
                end

                default: begin
                    state_nxt.cfg = state_r.cfg;
                end
            endcase
        end

        // Sequencer
        unique case (state_r.st)
            dbs_pkg::ST_IDLE: begin
                if (start && !blocked) begin
                    state_nxt.st = dbs_pkg::ST_RUN;
                end
            end

            dbs_pkg::ST_RUN: begin
                state_nxt.cnt = 17'h0_0000;
                if (blocked) begin
                    state_nxt.st = dbs_pkg::ST_DEMAG;
                end else if (!start) begin
                    // DC braking replaces the stop ramp in mode 1 only
                    state_nxt.st = brk_cancel ? dbs_pkg::ST_DEMAG : dbs_pkg::ST_STOP;
                end
            end

            dbs_pkg::ST_STOP: begin
                state_nxt.cnt = 17'h0_0000;
                if (blocked) begin
                    state_nxt.st = dbs_pkg::ST_DEMAG;
                end else if (start) begin
                    state_nxt.st = dbs_pkg::ST_RUN;
                end
            end

            dbs_pkg::ST_DEMAG: begin
                if (start && !blocked) begin
                    state_nxt.st = dbs_pkg::ST_RUN;
                end else if (state_r.cnt >= {1'b0, state_r.cfg.demag_delay}) begin
                    state_nxt.st  = dbs_pkg::ST_BRAKE;
                    state_nxt.cnt = 17'h0_0000;
                end else if (ten_ms_tick) begin
                    state_nxt.cnt = state_r.cnt + 17'h0_0001;
                end
            end

            dbs_pkg::ST_BRAKE: begin
                // Both intervals count from DC injection start
                if (start && !blocked && state_r.cnt >= {1'b0, state_r.cfg.brake_time_min}) begin
                    state_nxt.st = dbs_pkg::ST_RUN;
                end else if (state_r.cnt >= max_ms) begin
                    state_nxt.cnt = 17'h0_0000;
                    if (state_r.cfg.dc_hold_duration != 16'h0000) begin
                        state_nxt.st = dbs_pkg::ST_HOLD;
                    end else begin
                        state_nxt.st = dbs_pkg::ST_IDLE;
                    end
                end else if (ms_tick) begin
                    state_nxt.cnt = state_r.cnt + 17'h0_0001;
                end
            end

            dbs_pkg::ST_HOLD: begin
                if (start && !blocked) begin
                    state_nxt.st = dbs_pkg::ST_RUN;
                end else if (state_r.cnt >= {1'b0, state_r.cfg.dc_hold_duration}) begin
                    state_nxt.st = dbs_pkg::ST_IDLE;
                end else if (ten_ms_tick) begin
                    state_nxt.cnt = state_r.cnt + 17'h0_0001;
                end
            end

            default: begin
                state_nxt.st = dbs_pkg::ST_IDLE;
            end
        endcase

        // Drive commands follow the next state so they leave flops aligned with it
        state_nxt.drv.dc_inject      = state_nxt.st == dbs_pkg::ST_BRAKE || state_nxt.st == dbs_pkg::ST_HOLD;
        state_nxt.drv.dc_hold_active = state_nxt.st == dbs_pkg::ST_HOLD;
        state_nxt.drv.dc_current_pct = state_nxt.drv.dc_inject ?
                                       state_r.cfg.dc_brake_current_set : 8'h00;
        state_nxt.drv.coast          = state_nxt.st == dbs_pkg::ST_DEMAG ||
                                       (state_nxt.st == dbs_pkg::ST_STOP &&
                                        state_r.cfg.stop_action == dbs_pkg::ACT_COAST);
        state_nxt.drv.stop_ramp      = state_nxt.st == dbs_pkg::ST_STOP &&
                                       state_r.cfg.stop_action == dbs_pkg::ACT_RAMP;
        state_nxt.drv.brake_out      = pin_s.motor_holding_brake_fn &&
                                       state_nxt.st != dbs_pkg::ST_BRAKE;
    end

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r        <= '0;
            state_r.cfg    <= CFG_RST;
            state_r.st     <= dbs_pkg::ST_IDLE;
            state_r.pready <= 1'b1;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign prdata  = state_r.prdata;
    assign pready  = state_r.pready;
    assign pslverr = state_r.pslverr;
    assign drive   = state_r.drv;

endmodule : dbs_top

// [logic/dbs_pkg.sv]
/*
 * Shared constants, register map and carrier types of the DC braking sequencer.
 * Assumes a 20 MHz APB clock and a 32-bit APB data path.
 */
package dbs_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS = 50;
    localparam int MS_NS         = 1_000_000;
    localparam int CYC_PER_MS    = MS_NS / CLK_PERIOD_NS;
    localparam int MS_PER_TICK10 = 10;
    localparam int MS_PER_S      = 1000;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] OFS_CTRL    = 8'h00;
    localparam logic [7:0] OFS_CURRENT = 8'h04;
    localparam logic [7:0] OFS_DEMAG   = 8'h08;
    localparam logic [7:0] OFS_MIN     = 8'h0C;
    localparam logic [7:0] OFS_MAX     = 8'h10;
    localparam logic [7:0] OFS_HOLD    = 8'h14;
    localparam logic [7:0] OFS_STATUS  = 8'h18;

    // ****************************************************************
    // Field positions, limits and values after reset
    // ****************************************************************
    localparam int POS_MODE    = 0;
    localparam int POS_SWSTOP  = 2;
    localparam int POS_STOPACT = 3;
    localparam int POS_INJECT  = 4;

    localparam logic [1:0]  MODE_OFF          = 2'h0;
    localparam logic [1:0]  MODE_AFTER_CANCEL = 2'h1;
    localparam logic [1:0]  MODE_EXT_STOP     = 2'h2;
    localparam logic [1:0]  ACT_COAST         = 2'h0;
    localparam logic [1:0]  ACT_RAMP          = 2'h1;

    localparam logic [7:0]  CURRENT_MAX = 8'hB4;
    localparam logic [7:0]  CURRENT_RST = 8'h50;
    localparam logic [15:0] DEMAG_MIN   = 16'h000A;
    localparam logic [15:0] DEMAG_MAX   = 16'h03E8;
    localparam logic [15:0] DEMAG_RST   = 16'h00C8;
    localparam logic [15:0] MIN_RST     = 16'h0000;
    localparam logic [15:0] MAX_S_MAX   = 16'h003C;
    localparam logic [15:0] MAX_S_RST   = 16'h000F;
    localparam logic [15:0] HOLD_MAX    = 16'h1770;
    localparam logic [15:0] HOLD_RST    = 16'h0032;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [2:0] {
        ST_IDLE, ST_RUN, ST_STOP, ST_DEMAG, ST_BRAKE, ST_HOLD
    } dbs_state_type;

    typedef struct packed {
        logic [1:0]  dc_brake_mode_sel;
        logic        sw_stop;
        logic [1:0]  stop_action;
        logic [7:0]  dc_brake_current_set;
        logic [15:0] demag_delay;
        logic [15:0] brake_time_min;
        logic [15:0] brake_time_max;
        logic [15:0] dc_hold_duration;
    } dbs_cfg_type;

    typedef struct packed {
        logic start_clockwise;
        logic start_anticlockwise;
        logic stop_req_n;
        logic motor_holding_brake_fn;
    } dbs_pin_type;

    typedef struct packed {
        logic       dc_inject;
        logic [7:0] dc_current_pct;
        logic       dc_hold_active;
        logic       coast;
        logic       stop_ramp;
        logic       brake_out;
    } dbs_drive_type;

endpackage : dbs_pkg

// [logic/dbs_sync.sv]
/*
 * Two-stage synchroniser for the pin inputs of the braking sequencer.
 * Assumes the pins are asynchronous to pclk.
 */
module dbs_sync (
    // Clock and reset
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    // Pins
    input  wire dbs_pkg::dbs_pin_type pin_async,
    output      dbs_pkg::dbs_pin_type pin_sync
);

    typedef struct packed {
        dbs_pkg::dbs_pin_type meta;
        dbs_pkg::dbs_pin_type stable;
    } dbs_sync_state_type;

    dbs_sync_state_type state_r;
    dbs_sync_state_type state_nxt;

    always_comb begin
        state_nxt.meta   = pin_async;
        state_nxt.stable = state_r.meta;
    end

    // Stop request idles high, so reset mimics an inactive pin
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= {4'h2, 4'h2};
        end else begin
            state_r <= state_nxt;
        end
    end

    assign pin_sync = state_r.stable;

endmodule : dbs_sync

// [logic/dbs_tick.sv]
/*
 * Time base: one-cycle pulses every millisecond and every ten milliseconds.
 * Assumes CYC_PER_MS is at least 2.
 */
module dbs_tick #(
    parameter int CYC_PER_MS = dbs_pkg::CYC_PER_MS
) (
    // Clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // Ticks
    output      logic ms_tick,
    output      logic ten_ms_tick
);

    localparam int CW = $clog2(CYC_PER_MS);

    typedef struct packed {
        logic [CW-1:0] div;
        logic [3:0]    dec;
        logic          ms;
        logic          ten;
    } dbs_tick_state_type;

    dbs_tick_state_type state_r;
    dbs_tick_state_type state_nxt;

    always_comb begin
        state_nxt     = state_r;
        state_nxt.ms  = 1'b0;
        state_nxt.ten = 1'b0;
        if (state_r.div == CW'(CYC_PER_MS - 1)) begin
            state_nxt.div = '0;
            state_nxt.ms  = 1'b1;
            if (state_r.dec == 4'(dbs_pkg::MS_PER_TICK10 - 1)) begin
                state_nxt.dec = 4'h0;
                state_nxt.ten = 1'b1;
            end else begin
                state_nxt.dec = state_r.dec + 4'h1;
            end
        end else begin
            state_nxt.div = state_r.div + CW'(1);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= '0;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign ms_tick     = state_r.ms;
    assign ten_ms_tick = state_r.ten;

endmodule : dbs_tick

// [dv/dbs_chk.sv]
/* Port checker for the DC braking sequencer top.
   Assumes it is bound into dbs_top and sees only its ports. */
module dbs_chk #(
    parameter int CYC_PER_MS = dbs_pkg::CYC_PER_MS
) (
    // Clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // APB
    input wire logic [7:0]             paddr,
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic [31:0]            prdata,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // Drive
    input wire dbs_pkg::dbs_drive_type drive
);
    localparam int BRAKE_LIM = 60000 * CYC_PER_MS + 2 * CYC_PER_MS;
    int brake_cnt_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            brake_cnt_r <= 0;
        end else begin
            brake_cnt_r <= (drive.dc_inject && !drive.dc_hold_active) ? brake_cnt_r + 1 : 0;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    AST_PREADY: assert property (pready) else $error("pready low");
    AST_UNMAPPED: assert property (s_setup ##0 paddr >= 8'h1C |=> pslverr && prdata == 32'h0000_0000)
        else $error("unmapped access not refused");
    AST_READ_HOLD: assert property (s_setup |=> ##1 $stable(prdata)) else $error("read data moved");
    AST_FN_OFF: assert property (drive.dc_inject && !drive.dc_hold_active |-> !drive.brake_out)
        else $error("brake output during DC braking");
    AST_CUR_LIM: assert property (drive.dc_inject |-> drive.dc_current_pct <= 8'hB4)
        else $error("current above limit");
    AST_NO_MIX: assert property (!(drive.coast && drive.dc_inject)) else $error("coast with DC");
    AST_ONE_STOP: assert property (!(drive.coast && drive.stop_ramp)) else $error("coast with ramp");
    AST_DEMAG_FIRST: assert property ($rose(drive.dc_inject) |-> $past(drive.coast))
        else $error("DC without demagnetisation");
    AST_HOLD_AFTER: assert property ($rose(drive.dc_hold_active) |-> $past(drive.dc_inject))
        else $error("holding without braking");
    AST_RST_OFF: assert property ($rose(presetn) |-> !drive.dc_inject [*8])
        else $error("DC after reset");
    AST_MAX_TIME: assert property (brake_cnt_r <= BRAKE_LIM) else $error("braking too long");
endmodule : dbs_chk

bind dbs_top dbs_chk #(.CYC_PER_MS(CYC_PER_MS)) i_dbs_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive(drive));

// [dv/dbs_inv_model.sv]
/* Power stage and motor model: speed falls only under DC injection.
   Assumes the bench raises spin_up while the motor runs. */
module dbs_inv_model (
    // Clock and reset
    input wire logic                   pclk,
    input wire logic                   presetn,
    // Stimulus and drive
    input wire logic                   spin_up,
    input wire dbs_pkg::dbs_drive_type drive,
    // Motor
    output     int                     speed
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            speed <= 0;
        end else if (spin_up) begin
            speed <= 1000;
        end else if (drive.dc_inject && speed > 0) begin
            speed <= speed - 1;
        end
    end
endmodule : dbs_inv_model

// [dv/dbs_tb_top.sv]
/* Self-checking bench of the DC braking sequencer.
   Assumes dbs_pkg and the design files are compiled first. */
module dbs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int CYC = 4;
    logic                   pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, spin_up = 0;
    logic                   start_clockwise = 0, start_anticlockwise = 0, stop_req_n = 1;
    logic                   motor_holding_brake_fn = 0, e, pready, pslverr;
    logic [7:0]             paddr = 8'h00;
    logic [31:0]            pwdata = 32'h0000_0000, prdata, r;
    dbs_pkg::dbs_drive_type drive;
    int                     fails, compares, speed, t0, exp_reg[7] = '{0, 80, 200, 0, 15, 50, 0};
    dbs_top #(.CYC_PER_MS(CYC)) i_dbs_top (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'h3), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .start_clockwise(start_clockwise), .start_anticlockwise(start_anticlockwise),
        .stop_req_n(stop_req_n), .motor_holding_brake_fn(motor_holding_brake_fn), .drive(drive));
    dbs_inv_model i_dbs_inv_model (.pclk(pclk), .presetn(presetn), .spin_up(spin_up), .drive(drive), .speed(speed));
    always #25 pclk = ~pclk;
    task automatic chk(input bit ok, input string m);
        compares++;
        if (!ok) begin
            fails++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask : chk
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 0;
        penable <= 0;
    endtask : apb
    // Register model with the documented clamps
    task automatic wr(input int i, input int v);
        apb(8'(i * 4), 1, 32'(v));
        case (i)
            0: exp_reg[0] = v & 31;
            1: exp_reg[1] = (v & 255) > 180 ? 180 : v & 255;
            2: exp_reg[2] = v < 10 ? 10 : (v > 1000 ? 1000 : v);
            3: exp_reg[3] = v & 65535;
            4: exp_reg[4] = v > 60 ? 60 : v;
            5: exp_reg[5] = v > 6000 ? 6000 : v;
            default: chk(e === 1'b1, "status write");
        endcase
    endtask : wr
    task automatic wait_st(input int s, input int lim);
        int n;
        n = 0;
        do begin
            apb(8'h18, 0, 0);
            n++;
        end while (r[2:0] !== s[2:0] && n < lim);
        chk(r[2:0] === s[2:0], "state");
    endtask : wait_st
    task automatic test_done;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done
    initial begin
        #2_000_000;
        fails++;
        test_done();
    end
    initial begin
        void'($urandom(94880));
        repeat (16) @(posedge pclk);
        presetn <= 1;
        for (int i = 0; i < 6; i++) begin
            apb(8'(i * 4), 0, 0);
            chk(r === 32'(exp_reg[i]) && e === 1'b0, "reset value");
        end
        apb(8'h20, 0, 0);
        chk(e === 1'b1 && r === 32'h0000_0000, "unmapped");
        wr(6, 5);
        repeat (4) wr(1, $urandom % 256);
        apb(8'h04, 0, 0);
        chk(r === 32'(exp_reg[1]), "current clamp");
        start_clockwise <= 1;
        wait_st(1, 10);
        start_clockwise <= 0;
        wait_st(2, 10);
        chk(drive.coast === 1'b1 && drive.dc_inject === 1'b0, "coast stop");
        wr(0, 8);
        wait_st(2, 2);
        chk(drive.stop_ramp === 1'b1, "ramp stop");
        wr(2, 10);
        wr(3, 10);
        wr(4, 1);
        wr(5, 0);
        wr(0, 1);
        start_clockwise <= 1;
        spin_up <= 1;
        wait_st(1, 10);
        start_clockwise <= 0;
        spin_up <= 0;
        motor_holding_brake_fn <= 1;
        wait_st(3, 10);
        wait_st(4, 200);
        start_anticlockwise <= 1;
        chk(drive.dc_current_pct === 8'(exp_reg[1]) && drive.brake_out === 1'b0, "braking output");
        repeat (20) @(posedge pclk);
        wait_st(4, 1);
        wait_st(1, 20);
        chk(drive.brake_out === 1'b1, "holding brake back");
        start_anticlockwise <= 0;
        wait_st(4, 200);
        t0 = $time / 50;
        wait_st(0, 1500);
        chk($time / 50 - t0 >= 1000 * CYC - 16 && $time / 50 - t0 <= 1000 * CYC + 16, "brake time");
        chk(speed === 0, "motor braked");
        wr(4, 0);
        wr(5, 5);
        wr(0, 2);
        start_clockwise <= 1;
        wait_st(1, 10);
        start_clockwise <= 0;
        wait_st(2, 10);
        stop_req_n <= 0;
        wait_st(3, 10);
        wait_st(5, 200);
        chk(drive.dc_hold_active === 1'b1, "holding output");
        stop_req_n <= 1;
        wait_st(0, 100);
        start_clockwise <= 1;
        wait_st(1, 10);
        wr(0, 6);
        wait_st(3, 10);
        test_done();
    end
endmodule : dbs_tb_top
